/* logic/ccfg_top.v */
// Notes on behaviour
// - three byte registers hold auxiliary cursor colour
// - 11-bit x position plus 5-bit x hot spot
// - 10-bit y position plus 5-bit y hot spot
// - style zero inverts pixel colour under cursor
// - style one inserts auxiliary colour under cursor
// - load bit one feeds tables from stream
// - three-bit field selects input pixel format
// - control bits one bypass table, matrix, formatter
`timescale 1ns/1ps
`default_nettype none
`include "ccfg_defs.vh"

module ccfg_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = `CCFG_FIFO_DEPTH,
  parameter AW    = `CCFG_FIFO_AW
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst_b,
  // fill side
  input  wire             wrValid,
  output wire             wrReady,
  input  wire [WIDTH-1:0] wrData,
  // drain side
  output wire             rdValid,
  input  wire             rdReady,
  output wire [WIDTH-1:0] rdData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            doWrite;
  wire            doRead;

  assign wrReady = (count_q != DEPTH[AW:0]);
  assign rdValid = (count_q != {(AW+1){1'b0}});
  assign doWrite = wrValid & wrReady;
  assign doRead  = rdValid & rdReady;
  assign rdData  = mem[rdPtr_q];

  // storage holds no reset; only the pointers define content
  always @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead && !doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

module ccfg_byte_reg #(
  parameter [7:0] ADDR  = 8'h00,
  parameter [7:0] RESET = `CCFG_RST_BYTE
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_b,
  // register port
  input  wire       regWrite,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  // stored byte
  output reg  [7:0] value_q
);

  // whole-byte writes only; the port has no byte lanes or masks
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      value_q <= RESET;
    end else if (regWrite && (regAddr == ADDR)) begin
      value_q <= regWrData;
    end
  end

endmodule

module ccfg_top #(
  parameter FIFO_DEPTH = `CCFG_FIFO_DEPTH,
  parameter FIFO_AW    = `CCFG_FIFO_AW
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // subaddress register port
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  output reg  [7:0]  regRdData,
  output reg         regRdHit,
  // incoming pixel stream
  input  wire        pixValid,
  output wire        pixReady,
  input  wire [23:0] pixData,
  input  wire        pixCursor,
  // outgoing pixel stream
  output wire        outValid,
  input  wire        outReady,
  output wire [23:0] outData,
  // stream table loading
  output reg         tableLoadValid,
  output reg  [23:0] tableLoadData,
  // path configuration
  output wire [10:0] cursorXPosition,
  output wire [4:0]  cursorXHotspot,
  output wire [9:0]  cursorYPosition,
  output wire [4:0]  cursorYHotspot,
  output wire [2:0]  inputFormat,
  output wire        formatRgb888,
  output wire        formatRgb555,
  output wire        formatRgb565,
  output wire        formatYuv422,
  output wire        formatYuv422Interlaced,
  output wire        formatIndex8,
  output wire        formatRgb888Swapped,
  output wire        formatReserved,
  output wire        lookupTableBypass,
  output wire        colorMatrixBypass,
  output wire        downFormatterBypass,
  output wire        cursorStyle,
  output wire        tableLoadFromStream
);

  wire [7:0]  auxRed_q;
  wire [7:0]  auxGreen_q;
  wire [7:0]  auxBlue_q;
  wire [7:0]  xLow_q;
  wire [7:0]  xHigh_q;
  wire [7:0]  yLow_q;
  wire [7:0]  yHigh_q;
  wire [7:0]  inCtrl_q;
  reg  [23:0] drawData;
  wire        fifoWrValid;
  wire        fifoWrReady;
  wire        loadTake;

  // one register per subaddress, active from the next pixel
  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_AUX_RED)
  ) u_auxRed (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (auxRed_q)
  );

  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_AUX_GREEN)
  ) u_auxGreen (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (auxGreen_q)
  );

  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_AUX_BLUE)
  ) u_auxBlue (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (auxBlue_q)
  );

  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_X_LOW)
  ) u_xLow (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (xLow_q)
  );

  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_X_HIGH_HS)
  ) u_xHigh (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (xHigh_q)
  );

  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_Y_LOW)
  ) u_yLow (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (yLow_q)
  );

  // bit two is kept as written; host is expected to leave it zero
  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_Y_HIGH_HS)
  ) u_yHigh (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (yHigh_q)
  );

  ccfg_byte_reg #(
    .ADDR (`CCFG_ADDR_INPUT_CTRL)
  ) u_inCtrl (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .regWrite  (regWrite),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .value_q   (inCtrl_q)
  );

  // readback, one cycle after the read strobe; unmapped reads give zero
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
      regRdHit  <= 1'b0;
    end else if (regRead) begin
      regRdHit <= 1'b1;
      if (regAddr == `CCFG_ADDR_AUX_RED) begin
        regRdData <= auxRed_q;
      end else if (regAddr == `CCFG_ADDR_AUX_GREEN) begin
        regRdData <= auxGreen_q;
      end else if (regAddr == `CCFG_ADDR_AUX_BLUE) begin
        regRdData <= auxBlue_q;
      end else if (regAddr == `CCFG_ADDR_X_LOW) begin
        regRdData <= xLow_q;
      end else if (regAddr == `CCFG_ADDR_X_HIGH_HS) begin
        regRdData <= xHigh_q;
      end else if (regAddr == `CCFG_ADDR_Y_LOW) begin
        regRdData <= yLow_q;
      end else if (regAddr == `CCFG_ADDR_Y_HIGH_HS) begin
        regRdData <= yHigh_q;
      end else if (regAddr == `CCFG_ADDR_INPUT_CTRL) begin
        regRdData <= inCtrl_q;
      end else begin
        regRdData <= 8'h00;
        regRdHit  <= 1'b0;
      end
    end else begin
      regRdHit <= 1'b0;
    end
  end

  // field views
  assign cursorXPosition = {xHigh_q[`CCFG_XHI_MSB:0], xLow_q};
  assign cursorXHotspot  = xHigh_q[`CCFG_HS_MSB:`CCFG_HS_LSB];
  assign cursorYPosition = {yHigh_q[`CCFG_YHI_MSB:0], yLow_q};
  assign cursorYHotspot  = yHigh_q[`CCFG_HS_MSB:`CCFG_HS_LSB];

  assign lookupTableBypass   = inCtrl_q[`CCFG_BIT_LUT_BYPASS];
  assign colorMatrixBypass   = inCtrl_q[`CCFG_BIT_MAT_BYPASS];
  assign downFormatterBypass = inCtrl_q[`CCFG_BIT_DF_BYPASS];
  assign cursorStyle         = inCtrl_q[`CCFG_BIT_CURSOR_STYLE];
  assign tableLoadFromStream = inCtrl_q[`CCFG_BIT_TABLE_LOAD];
  assign inputFormat         = inCtrl_q[`CCFG_FMT_MSB:`CCFG_FMT_LSB];

  // one-hot format decode; code 111 is unassigned
  assign formatRgb888           = (inputFormat == `CCFG_FMT_RGB888);
  assign formatRgb555           = (inputFormat == `CCFG_FMT_RGB555);
  assign formatRgb565           = (inputFormat == `CCFG_FMT_RGB565);
  assign formatYuv422           = (inputFormat == `CCFG_FMT_YUV422);
  // the line length for this mode lives in another block
  assign formatYuv422Interlaced = (inputFormat == `CCFG_FMT_YUV422I);
  assign formatIndex8           = (inputFormat == `CCFG_FMT_INDEX8);
  assign formatRgb888Swapped    = (inputFormat == `CCFG_FMT_RGB888_SWAP);
  assign formatReserved         = (inputFormat == 3'h7);

  // cursor overlay before buffering, so a stalled sink never sees a style
  // change half way through an already queued pixel
  always @* begin
    drawData = pixData;
    if (pixCursor) begin
      if (cursorStyle) begin
        drawData = {auxRed_q, auxGreen_q, auxBlue_q};
      end else begin
        drawData = ~pixData;
      end
    end
  end

  // while stream loading, pixels go to the tables, not to the display path
  assign loadTake    = pixValid & tableLoadFromStream;
  assign fifoWrValid = pixValid & ~tableLoadFromStream;
  assign pixReady    = tableLoadFromStream ? 1'b1 : fifoWrReady;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      tableLoadValid <= 1'b0;
      tableLoadData  <= 24'h000000;
    end else begin
      tableLoadValid <= loadTake;
      if (loadTake) begin
        tableLoadData <= pixData;
      end
    end
  end

  ccfg_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wrValid (fifoWrValid),
    .wrReady (fifoWrReady),
    .wrData  (drawData),
    .rdValid (outValid),
    .rdReady (outReady),
    .rdData  (outData)
  );

endmodule

`default_nettype wire

/* inc/ccfg_defs.vh */
`ifndef CCFG_DEFS_VH
`define CCFG_DEFS_VH

// subaddresses
`define CCFG_ADDR_AUX_RED     8'hF6
`define CCFG_ADDR_AUX_GREEN   8'hF7
`define CCFG_ADDR_AUX_BLUE    8'hF8
`define CCFG_ADDR_X_LOW       8'hF9
`define CCFG_ADDR_X_HIGH_HS   8'hFA
`define CCFG_ADDR_Y_LOW       8'hFB
`define CCFG_ADDR_Y_HIGH_HS   8'hFC
`define CCFG_ADDR_INPUT_CTRL  8'hFD

// reset values
`define CCFG_RST_BYTE         8'h00

// field positions in the high/hot-spot registers
`define CCFG_HS_MSB           7
`define CCFG_HS_LSB           3
`define CCFG_XHI_MSB          2
`define CCFG_YHI_MSB          1

// field positions in the input path control register
`define CCFG_BIT_LUT_BYPASS   7
`define CCFG_BIT_CURSOR_STYLE 6
`define CCFG_BIT_TABLE_LOAD   5
`define CCFG_FMT_MSB          4
`define CCFG_FMT_LSB          2
`define CCFG_BIT_MAT_BYPASS   1
`define CCFG_BIT_DF_BYPASS    0

// input format codes
`define CCFG_FMT_RGB888       3'h0
`define CCFG_FMT_RGB555       3'h1
`define CCFG_FMT_RGB565       3'h2
`define CCFG_FMT_YUV422       3'h3
`define CCFG_FMT_YUV422I      3'h4
`define CCFG_FMT_INDEX8       3'h5
`define CCFG_FMT_RGB888_SWAP  3'h6

// fifo
`define CCFG_FIFO_DEPTH       16
`define CCFG_FIFO_AW          4

`endif

/* test/ccfg_pix_src.sv */
`timescale 1ns/1ps
`default_nettype none
module ccfg_pix_src (
  input  wire logic        sys_clk,
  input  wire logic        pixReady,
  output var  logic        pixValid,
  output var  logic [23:0] pixData,
  output var  logic        pixCursor
);
  initial begin
    pixValid = 1'b0;
    pixData = 24'h000000;
    pixCursor = 1'b0;
  end
  // released lines show the inverse so stale data never matches
  task send(input logic [23:0] d, input logic c);
    @(posedge sys_clk);
    pixValid <= 1'b1;
    pixData <= d;
    pixCursor <= c;
    @(posedge sys_clk);
    while (!pixReady) @(posedge sys_clk);
    pixValid <= 1'b0;
    pixData <= ~d;
    pixCursor <= ~c;
  endtask
endmodule
`default_nettype wire

/* test/ccfg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ccfg_checker (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        regRdHit,
  input wire logic        pixValid,
  input wire logic        pixReady,
  input wire logic [23:0] pixData,
  input wire logic        pixCursor,
  input wire logic        outValid,
  input wire logic [23:0] outData,
  input wire logic        tableLoadValid,
  input wire logic [23:0] tableLoadData,
  input wire logic [10:0] cursorXPosition,
  input wire logic [4:0]  cursorXHotspot,
  input wire logic [9:0]  cursorYPosition,
  input wire logic [4:0]  cursorYHotspot,
  input wire logic [2:0]  inputFormat,
  input wire logic        lookupTableBypass,
  input wire logic        colorMatrixBypass,
  input wire logic        downFormatterBypass,
  input wire logic        cursorStyle,
  input wire logic        tableLoadFromStream
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire take = pixValid && pixReady;
  a_x_fields: assert property (regWrite && regAddr == 8'hFA |=>
    {cursorXHotspot, cursorXPosition[10:8]} == $past(regWrData)) else $error("x field");
  a_y_fields: assert property (regWrite && regAddr == 8'hFC |=>
    {cursorYHotspot, cursorYPosition[9:8]} == {$past(regWrData[7:3]), $past(regWrData[1:0])})
    else $error("y field");
  a_ctrl_bits: assert property (regWrite && regAddr == 8'hFD |=>
    {lookupTableBypass, cursorStyle, tableLoadFromStream, inputFormat, colorMatrixBypass,
    downFormatterBypass} == $past(regWrData)) else $error("control bits");
  a_read_hit: assert property (regRead && regAddr inside {[8'hF6:8'hFD]} |=> regRdHit)
    else $error("mapped read");
  a_read_miss: assert property (regRead && !(regAddr inside {[8'hF6:8'hFD]}) |=>
    !regRdHit && regRdData == 8'h00) else $error("unmapped read");
  a_invert_pix: assert property (take && pixCursor && !cursorStyle && !tableLoadFromStream
    && !outValid |=> outValid && outData == ~$past(pixData)) else $error("invert");
  a_load_pulse: assert property (take && tableLoadFromStream |=>
    tableLoadValid && tableLoadData == $past(pixData)) else $error("load");
  a_load_idle: assert property (!(take && tableLoadFromStream) |=> !tableLoadValid)
    else $error("no load");
  a_load_ready: assert property (tableLoadFromStream |-> pixReady) else $error("ready");
endmodule
bind ccfg_top ccfg_checker i_chk (.*);
`default_nettype wire

/* test/ccfg_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ccfg_top_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        outReady = 1'b0;
  logic [7:0]  regRdData;
  logic        regRdHit, pixValid, pixReady, pixCursor, outValid, tableLoadValid;
  logic [23:0] pixData, outData, tableLoadData;
  logic [10:0] cursorXPosition;
  logic [9:0]  cursorYPosition;
  logic [4:0]  cursorXHotspot, cursorYHotspot;
  logic [2:0]  inputFormat;
  logic        lookupTableBypass, colorMatrixBypass, downFormatterBypass;
  logic        cursorStyle, tableLoadFromStream;
  wire logic [7:0] fmtHot;
  int          err_total = 0;
  int          check_count = 0;
  always #4 sys_clk = ~sys_clk;
  ccfg_top i_dut (.*, .formatRgb888(fmtHot[0]), .formatRgb555(fmtHot[1]),
    .formatRgb565(fmtHot[2]), .formatYuv422(fmtHot[3]), .formatYuv422Interlaced(fmtHot[4]),
    .formatIndex8(fmtHot[5]), .formatRgb888Swapped(fmtHot[6]), .formatReserved(fmtHot[7]));
  ccfg_pix_src i_src (.*);
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk({15'h0, regRdHit, regRdData}, {15'h0, h, e});
  endtask
  task pop(input logic [23:0] e);
    @(posedge sys_clk);
    outReady <= 1'b1;
    @(posedge sys_clk);
    while (!outValid) @(posedge sys_clk);
    outReady <= 1'b0;
    chk(outData, e);
  endtask
  function automatic logic [7:0] v(input logic [7:0] a);
    return a ^ 8'h3C;
  endfunction
  task summarize;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // long enough for about 12500 cycles of traffic
  initial begin
    #100000;
    err_total++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 8'hF6; a <= 8'hFD; a++) rd(a[7:0], 8'h00, 1'b1);
    chk({21'h0, pixReady, outValid, tableLoadValid}, {21'h0, 3'b100});
    for (int a = 8'hF6; a <= 8'hFD; a++) wr(a[7:0], v(a[7:0]));
    for (int a = 8'hF6; a <= 8'hFE; a++) rd(a[7:0], a == 8'hFE ? 8'h00 : v(a[7:0]), a != 8'hFE);
    chk({8'h0, cursorXHotspot, cursorXPosition}, {8'h0, v(8'hFA), v(8'hF9)});
    chk({8'h0, cursorYHotspot, 1'b0, cursorYPosition}, {8'h0, v(8'hFC), v(8'hFB)});
    i_src.send(24'h123456, 1'b1);
    pop({v(8'hF6), v(8'hF7), v(8'hF8)});
    for (logic [3:0] f = 4'h0; f < 4'h8; f++) begin
      wr(8'hFD, {f[0], 2'b00, f[2:0], f[1], ~f[0]});
      #1 chk({18'h0, inputFormat, lookupTableBypass, colorMatrixBypass, downFormatterBypass},
        {18'h0, f[2:0], f[0], f[1], ~f[0]});
      chk({16'h0, fmtHot}, {16'h0, 8'h01 << f[2:0]});
    end
    i_src.send(24'h123456, 1'b1);
    i_src.send(24'hA5A5A5, 1'b0);
    pop(24'hEDCBA9);
    pop(24'hA5A5A5);
    // fill with the sink stalled, then drain in order
    for (int i = 0; i < 16; i++) i_src.send(24'(i), 1'b0);
    #1 chk({23'h0, pixReady}, 24'h0);
    for (int i = 0; i < 16; i++) pop(24'(i));
    wr(8'hFD, 8'h20);
    i_src.send(24'h0F0F0F, 1'b1);
    #1 chk(tableLoadData, 24'h0F0F0F);
    chk({22'h0, tableLoadValid, outValid}, {22'h0, 2'b10});
    summarize;
  end
endmodule
`default_nettype wire
